/* File: hw/acm_pkg.sv */
// Package of constants, types and layouts for the calibration multiply-add stage
package acm_pkg;

    // Datapath widths
    localparam int RAW_W   = 12;
    localparam int OUT_W   = 14;
    localparam int GAIN_W  = 15;
    localparam int OFFS_W  = 14;
    localparam int GAIN_FRAC = 14;

    // Unity gain (1.0 in 1.14 fixed point) and zero offset
    localparam logic [GAIN_W-1:0] GAIN_UNITY  = 15'h4000;
    localparam logic [OFFS_W-1:0] OFFS_ZERO   = 14'h0000;

    // Half-LSB adder in 14-bit units, and the x4 scaling shift
    localparam logic [OUT_W-1:0]  HALF_LSB    = 14'h0002;
    localparam int                SCALE_SHIFT = 2;

    // Saturation limits
    localparam logic [OUT_W-1:0]  OUT_MAX     = 14'h3FFF;
    localparam logic [OUT_W-1:0]  OUT_MIN     = 14'h0000;

    // Calibration reference codes on the 12-bit scale
    localparam logic [RAW_W-1:0]  REF_QUARTER = 12'h400;
    localparam logic [RAW_W-1:0]  REF_THREEQ  = 12'hC00;
    localparam logic [RAW_W-1:0]  REF_MID_CAL = 12'h7F0;

    // Buffer depth
    localparam int BUF_DEPTH = 2;

    // Raw sample with the command's calibration flag
    typedef struct packed {
        logic             cal;
        logic [RAW_W-1:0] raw;
    } acm_in_type;

    // Corrected result with the flag it was produced under
    typedef struct packed {
        logic             cal;
        logic [OUT_W-1:0] result;
    } acm_out_type;

endpackage

/* File: hw/acm_buffer.sv */
// Two-entry valid/ready buffer for corrected results
`timescale 1ns/1ps
module acm_buffer
#(
    parameter int DEPTH = acm_pkg::BUF_DEPTH
)
(
    input  wire logic                 i_clk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_valid,
    output logic                      o_ready,
    input  wire acm_pkg::acm_out_type i_data,
    output logic                      o_valid,
    input  wire logic                 i_ready,
    output acm_pkg::acm_out_type      o_data
);
    import acm_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    acm_out_type     mem_reg [DEPTH];
    acm_out_type     head_reg;
    logic            valid_reg;
    logic [PW-1:0]   wr_reg;
    logic [PW-1:0]   rd_reg;
    logic [PW:0]     cnt_reg;
    wire  [PW-1:0]   rd_next;
    wire  [PW:0]     cnt_next;
    acm_out_type     head_next;
    wire             push;
    wire             pop;
    wire             full;
    wire             empty;

    ////////////////////////////////////////////////////////////////////////
    // Handshake decode; full and empty come straight from the count
    assign full    = (cnt_reg == (PW+1)'(DEPTH));
    assign empty   = (cnt_reg == '0);
    assign push    = i_valid && !full;
    assign pop     = !empty && i_ready;
    assign o_ready = !full;

    // Output side comes from flops so o_valid and o_data have no logic
    assign o_valid = valid_reg;
    assign o_data  = head_reg;

    // Pointer wrap, shared by both pointers
    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    // Next read slot and count; the head copy must see a word written
    // into the very slot that becomes the head on this edge
    assign rd_next   = pop ? bump(rd_reg) : rd_reg;
    assign cnt_next  = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    assign head_next = (push && (wr_reg == rd_next)) ? i_data : mem_reg[rd_next];

    ////////////////////////////////////////////////////////////////////////
    // Storage, pointers and the registered head word
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_reg    <= '0;
            rd_reg    <= '0;
            cnt_reg   <= '0;
            head_reg  <= '0;
            valid_reg <= 1'b0;
            for (int k = 0; k < DEPTH; k++)
                mem_reg[k] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_reg[wr_reg] <= i_data;
                wr_reg          <= bump(wr_reg);
            end
            rd_reg    <= rd_next;
            cnt_reg   <= cnt_next;
            head_reg  <= head_next;
            valid_reg <= (cnt_next != '0);
        end
    end

endmodule

/* File: hw/acm_core.sv */
// Calibration multiply-add stage: gain and offset correction to 14-bit results
`timescale 1ns/1ps
module acm_core
(
    input  wire logic                        i_clk,
    input  wire logic                        i_nrst,
    // Coefficients, held stable by software before a calibrated conversion
    input  wire logic [acm_pkg::GAIN_W-1:0]  i_gain_correction_coefficient,
    input  wire logic [acm_pkg::OFFS_W-1:0]  i_offset_correction_coefficient,
    // Samples from the redundant signed digit stage
    input  wire logic                        i_in_valid,
    input  wire acm_pkg::acm_in_type         i_in_data,
    output logic                             o_in_ready,
    // Corrected results
    output logic                             o_out_valid,
    output acm_pkg::acm_out_type             o_out_data,
    input  wire logic                        i_out_ready
);
    import acm_pkg::*;

    // Product and sum widths: 12x15 product, then a sign bit and headroom
    localparam int PROD_W = RAW_W + GAIN_W;
    localparam int SUM_W  = PROD_W + 2;
    // Scaled product keeps its top bit so a gain above one reaches the clamp
    localparam int SCL_W  = PROD_W - (GAIN_FRAC - SCALE_SHIFT);

    typedef enum {ST_IDLE, ST_HOLD} acm_state_type;

    acm_state_type      state_reg;
    acm_state_type      state_next;
    acm_out_type        stage_reg;
    logic               stage_vld_reg;
    logic               in_ready_reg;
    wire                buf_ready;
    wire                take;
    wire                stage_pop;
    wire [PROD_W-1:0]   product;
    wire [SCL_W-1:0]    scaled;
    wire signed [SUM_W-1:0] cal_sum;
    wire [OUT_W-1:0]    cal_sat;
    wire [OUT_W-1:0]    uncal_res;
    wire [OUT_W-1:0]    sel_res;
    acm_out_type        result;

    ////////////////////////////////////////////////////////////////////////
    // Saturate a signed sum to the 14-bit code range
    function automatic logic [OUT_W-1:0] clamp(input logic signed [SUM_W-1:0] v);
        if (v < 0)
            clamp = OUT_MIN;
        else if (v > $signed({{(SUM_W-OUT_W){1'b0}}, OUT_MAX}))
            clamp = OUT_MAX;
        else
            clamp = v[OUT_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Calibrated path: gain (1.14) times raw gives 14-bit units directly,
    // since the 12-bit raw scaled by four equals raw times 2^14 >> 12.
    // Truncation of the product fraction is traded for a smaller adder.
    assign product = PROD_W'(i_gain_correction_coefficient) * PROD_W'(i_in_data.raw);
    assign scaled  = product[PROD_W-1:GAIN_FRAC-SCALE_SHIFT];
    assign cal_sum = $signed({{(SUM_W-SCL_W){1'b0}}, scaled})
                   + {{(SUM_W-OFFS_W){i_offset_correction_coefficient[OFFS_W-1]}},
                      i_offset_correction_coefficient}
                   + $signed({{(SUM_W-OUT_W){1'b0}}, HALF_LSB});
    assign cal_sat = clamp(cal_sum);

    // Uncalibrated path: x4 plus half LSB, cannot overflow 14 bits
    assign uncal_res = {i_in_data.raw, {SCALE_SHIFT{1'b0}}} + HALF_LSB;

    // Path select by the command's calibration flag
    assign sel_res = i_in_data.cal ? cal_sat : uncal_res;
    assign result  = {i_in_data.cal, sel_res};

    ////////////////////////////////////////////////////////////////////////
    // Handshake: one staged result, drained into the buffer
    assign take      = i_in_valid && in_ready_reg;
    assign stage_pop = stage_vld_reg && buf_ready;

    // Stage control: HOLD while a result waits on a stalled buffer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (take)
                    state_next = ST_HOLD;
            ST_HOLD:
                if (stage_pop && !take)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Result stage register; ready is registered so it stays a flop output
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_reg     <= ST_IDLE;
            stage_reg     <= '0;
            stage_vld_reg <= 1'b0;
            in_ready_reg  <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            if (take)
                stage_reg <= result;
            stage_vld_reg <= (state_next == ST_HOLD);
            // Accept next only when the stage will be free or draining
            in_ready_reg  <= (state_next == ST_IDLE);
        end
    end

    assign o_in_ready = in_ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // Output buffer so a stalled receiver loses no word
    acm_buffer #(
        .DEPTH   (BUF_DEPTH)
    ) u_buf (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_valid (stage_vld_reg),
        .o_ready (buf_ready),
        .i_data  (stage_reg),
        .o_valid (o_out_valid),
        .i_ready (i_out_ready),
        .o_data  (o_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks; sample and coefficients are read at the take edge and the
    // staged result one edge later, so $past gives the taken raw value
    // Uncalibrated: coefficients play no part, only x4 and the half LSB
    chk_uncal_format: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && !i_in_data.cal |=> stage_reg.result == {$past(i_in_data.raw), 2'b10})
        else $error("uncalibrated result not raw*4+2");

    // Unity gain and zero offset are transparent apart from the half LSB
    chk_unity_gain: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_gain_correction_coefficient == GAIN_UNITY
        && i_offset_correction_coefficient == OFFS_ZERO
        |=> stage_reg.result == {$past(i_in_data.raw), 2'b10})
        else $error("unity calibration changed the response");

    // The flag travels with its own result
    chk_cal_select: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take |=> stage_reg.cal == $past(i_in_data.cal))
        else $error("calibration flag lost");

    // Most negative offset on a zero sample clamps instead of wrapping high
    chk_sat_low: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_in_data.raw == '0
        && i_offset_correction_coefficient == 14'h2000 |=> stage_reg.result == OUT_MIN)
        else $error("negative sum did not clamp to zero");

    // Largest gain on a full-scale sample clamps instead of wrapping low
    chk_sat_high: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_in_data.raw == 12'hFFF
        && i_gain_correction_coefficient == 15'h7FFF |=> stage_reg.result == OUT_MAX)
        else $error("overflow did not clamp to full scale");

    // Offset of one on the quarter point shows the extra two of the half LSB
    chk_half_lsb: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_gain_correction_coefficient == GAIN_UNITY
        && i_offset_correction_coefficient == 14'h0001
        && i_in_data.raw == REF_QUARTER |=> stage_reg.result == 14'h1003)
        else $error("half LSB adder missing");

    // Reference points at unity land on the quarter and three-quarter codes plus the half LSB
    chk_ref_points: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_gain_correction_coefficient == GAIN_UNITY
        && i_offset_correction_coefficient == OFFS_ZERO
        && (i_in_data.raw == REF_QUARTER || i_in_data.raw == REF_THREEQ)
        |=> stage_reg.result == (($past(i_in_data.raw) == REF_QUARTER) ? 14'h1002 : 14'h3002))
        else $error("reference point not at quarter or three-quarter scale");

    // Calibrated mid-scale channel reads 2032 on the 12-bit scale
    chk_mid_cal: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_gain_correction_coefficient == GAIN_UNITY
        && i_offset_correction_coefficient == OFFS_ZERO
        && i_in_data.raw == REF_MID_CAL |=> stage_reg.result == 14'h1FC2)
        else $error("mid-scale channel not at the calibrated code");

    // Small positive offsets add straight onto the scaled sample
    chk_offset_add: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take && i_in_data.cal && i_gain_correction_coefficient == GAIN_UNITY
        && i_offset_correction_coefficient < 14'h1000 && i_in_data.raw < 12'h800
        |=> stage_reg.result == {$past(i_in_data.raw), 2'b10}
            + $past(i_offset_correction_coefficient))
        else $error("offset not added to the scaled sample");

    // A staged result may not change or vanish while the buffer is full
    chk_stage_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        stage_vld_reg && !buf_ready |=> stage_vld_reg && $stable(stage_reg))
        else $error("staged result dropped under stall");

    // The word shown to a stalled receiver stays put
    chk_out_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
        else $error("waiting result changed under back-pressure");

    // No back-to-back takes: ready falls after every accept
    chk_ready_stall: assert property (@(posedge i_clk) disable iff (!i_nrst)
        take |=> !o_in_ready)
        else $error("ready not dropped after accept");

endmodule

/* File: verification/acm_src_model.sv */
// Source model: conversion stage offering raw samples with their calibration flag
`timescale 1ns/1ps
module acm_src_model
(
    input  wire logic           i_clk,
    input  wire logic           i_in_ready,
    output logic                o_in_valid,
    output acm_pkg::acm_in_type o_in_data
);
    import acm_pkg::*;

    // Idle at time zero, nothing offered
    initial
    begin
        o_in_valid = 1'b0;
        o_in_data  = '0;
    end

    // Offer one word, hold it until taken; ready is a register, so read it mid-cycle
    task automatic send(input acm_in_type w, input int gap);
        repeat (gap)
        begin
            @(posedge i_clk);
            #1;
        end
        o_in_valid = 1'b1;
        o_in_data  = w;
        do @(negedge i_clk); while (i_in_ready !== 1'b1);
        @(posedge i_clk);
        #1;
        o_in_valid = 1'b0;
        // Stale word inverted so a late read cannot match by luck
        o_in_data  = acm_in_type'(~w);
    endtask
endmodule

/* File: verification/acm_core_tb_top.sv */
// Testbench: boundary and random samples through the calibration multiply-add stage
`timescale 1ns/1ps
module acm_core_tb_top;
    import acm_pkg::*;

    logic              i_clk      = 1'b0;
    logic              i_nrst     = 1'b0;
    logic [GAIN_W-1:0] gain       = GAIN_UNITY;
    logic [OFFS_W-1:0] offs       = OFFS_ZERO;
    logic              out_ready  = 1'b0;
    logic              stall      = 1'b0;
    logic [31:0]       seed       = 32'h922A2BCC;
    int                fail_count = 0;
    int                n_checks   = 0;
    int                i;
    logic              in_valid;
    logic              in_ready;
    logic              out_valid;
    acm_in_type        in_data;
    acm_out_type       out_data;
    acm_out_type       exp_q[$];

    always #12.5 i_clk = ~i_clk;

    acm_core DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_gain_correction_coefficient(gain),
        .i_offset_correction_coefficient(offs), .i_in_valid(in_valid), .i_in_data(in_data),
        .o_in_ready(in_ready), .o_out_valid(out_valid), .o_out_data(out_data),
        .i_out_ready(out_ready));

    acm_src_model u_src (.i_clk(i_clk), .i_in_ready(in_ready), .o_in_valid(in_valid),
        .o_in_data(in_data));

    ////////////////////////////////////////////////////////////////////////////////
    // Xorshift source, fixed seed so runs repeat
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected result; wide signed sum so clamping is seen, not wrapping
    function automatic acm_out_type calc(input acm_in_type w);
        logic signed [31:0] s;
        s = 32'(w.raw) << 2;
        if (w.cal)
            s = 32'((27'(gain) * 27'(w.raw)) >> 12) + 32'(signed'(offs));
        s = s + 2;
        if (s < 0)
            s = 0;
        if (s > 32'sh3FFF)
            s = 32'sh3FFF;
        return {w.cal, s[OUT_W-1:0]};
    endfunction

    // Coefficients set before the sample is offered and held until it is taken
    task automatic put(input logic c, input logic [RAW_W-1:0] r,
                       input logic [GAIN_W-1:0] g, input logic [OFFS_W-1:0] o);
        @(posedge i_clk);
        #1;
        gain = g;
        offs = o;
        exp_q.push_back(calc({c, r}));
        u_src.send({c, r}, xs() % 3);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver: mostly ready, random back-pressure, full stall on request
    always @(posedge i_clk)
        out_ready <= #1 !stall && ((xs() & 3) != 0);

    // Monitor: a pop is decided mid-cycle, the oldest note is compared
    always @(negedge i_clk)
    begin
        if (out_valid === 1'b1 && out_ready === 1'b1)
        begin
            n_checks++;
            if (exp_q.size() == 0 || out_data !== exp_q[0])
            begin
                $display("BAD %0t got %h exp %h", $time, out_data, exp_q[0]);
                fail_count++;
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    // Watchdog sized well past the sequence length
    initial
    begin
        #(25 * 30000);
        fail_count++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (3) @(posedge i_clk);
        #1;
        n_checks++;
        if (in_ready !== 1'b0 || out_valid !== 1'b0)
        begin
            $display("BAD %0t got %h exp %h", $time, {in_ready, out_valid}, 2'h0);
            fail_count++;
        end
        i_nrst = 1'b1;
        put(1'b0, 12'hFFF, GAIN_UNITY, OFFS_ZERO);
        put(1'b0, 12'h000, 15'h7FFF, 14'h1FFF);
        put(1'b1, REF_MID_CAL, GAIN_UNITY, OFFS_ZERO);
        put(1'b1, REF_QUARTER, GAIN_UNITY, OFFS_ZERO);
        put(1'b1, REF_QUARTER, GAIN_UNITY, 14'h0001);
        put(1'b1, REF_THREEQ, GAIN_UNITY, OFFS_ZERO);
        put(1'b1, REF_THREEQ, 15'h3C00, 14'h0010);
        put(1'b1, 12'h123, 15'h4400, 14'h3FF0);
        put(1'b1, 12'hFFF, 15'h7FFF, 14'h1FFF);
        put(1'b1, 12'h000, 15'h0000, 14'h2000);
        // Stalled receiver: two buffered, one staged, the fourth must wait
        stall = 1'b1;
        fork
            repeat (4) put(1'(xs()), 12'(xs()), 15'(xs()), 14'(xs()));
            begin
                repeat (30) @(posedge i_clk);
                #1;
                n_checks++;
                if (in_ready !== 1'b0)
                begin
                    $display("BAD %0t got %h exp %h", $time, in_ready, 1'b0);
                    fail_count++;
                end
                stall = 1'b0;
            end
        join
        for (i = 0; i < 300; i++)
            put(1'(xs()), 12'(xs()), 15'(xs()), 14'(xs()));
        for (i = 0; i < 100 && exp_q.size() != 0; i++)
            @(posedge i_clk);
        if (exp_q.size() != 0)
            fail_count++;
        final_report();
    end
endmodule
